// ### design/brsp_pkg.sv
// Purpose: Shared constants for the remote status and pattern controller
// Assumes: Commands arrive already parsed into a code and a binary argument
// Notes:   Times are in ns; cycle counts derive from the 10 MHz clock
package brsp_pkg;
  localparam int CLK_PERIOD_NS    = 100;
  localparam int SELFTEST_TIME_NS = 10000;
  localparam int SETTLE_TIME_NS   = 2000;
  localparam int SELFTEST_CYCLES  =
    (SELFTEST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYCLES    =
    (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SELFTEST_CNT = 8'(SELFTEST_CYCLES);
  localparam logic [7:0] SETTLE_CNT   = 8'(SETTLE_CYCLES);

  // Command codes
  localparam logic [4:0] CMD_CLS    = 5'h00;
  localparam logic [4:0] CMD_ESE    = 5'h01;
  localparam logic [4:0] CMD_ESE_Q  = 5'h02;
  localparam logic [4:0] CMD_ESR_Q  = 5'h03;
  localparam logic [4:0] CMD_IDN_Q  = 5'h04;
  localparam logic [4:0] CMD_LRN_Q  = 5'h05;
  localparam logic [4:0] CMD_OPC    = 5'h06;
  localparam logic [4:0] CMD_OPC_Q  = 5'h07;
  localparam logic [4:0] CMD_SRE    = 5'h08;
  localparam logic [4:0] CMD_SRE_Q  = 5'h09;
  localparam logic [4:0] CMD_STB_Q  = 5'h0a;
  localparam logic [4:0] CMD_TST_Q  = 5'h0b;
  localparam logic [4:0] CMD_WAI    = 5'h0c;
  localparam logic [4:0] CMD_TSE    = 5'h0d;
  localparam logic [4:0] CMD_TSE_Q  = 5'h0e;
  localparam logic [4:0] CMD_TSTAT_Q = 5'h0f;
  localparam logic [4:0] CMD_INV    = 5'h10;
  localparam logic [4:0] CMD_INV_Q  = 5'h11;
  localparam logic [4:0] CMD_PAT    = 5'h12;
  localparam logic [4:0] CMD_PAT_Q  = 5'h13;
  localparam logic [4:0] CMD_PRBS   = 5'h14;
  localparam logic [4:0] CMD_PRBS_Q = 5'h15;

  // Pattern modes
  localparam logic [1:0] MODE_PRBS  = 2'h0;
  localparam logic [1:0] MODE_WORD  = 2'h1;
  localparam logic [1:0] MODE_RDATA = 2'h2;

  // PRBS exponents
  localparam logic [4:0] PRBS_N7  = 5'h07;
  localparam logic [4:0] PRBS_N15 = 5'h0f;
  localparam logic [4:0] PRBS_N17 = 5'h11;
  localparam logic [4:0] PRBS_N20 = 5'h14;
  localparam logic [4:0] PRBS_N23 = 5'h17;

  // Reset values
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic       RST_INVERT = 1'b0;
  localparam logic [1:0] RST_MODE   = MODE_PRBS;
  localparam logic [4:0] RST_PRBS_N = PRBS_N23;

  // Status bit positions
  localparam int ESR_OPC_BIT = 0;
  localparam int ESR_CME_BIT = 5;
  localparam int STB_TSS_BIT = 3;
  localparam int STB_ESB_BIT = 5;
  localparam int STB_MSS_BIT = 6;
  localparam logic [7:0] MSS_EXCL_MASK = 8'hbf;
  localparam logic [15:0] OPC_ASCII_ONE = 16'h0031;

  // Reply tags
  localparam logic [3:0] TAG_NUM     = 4'h0;
  localparam logic [3:0] TAG_MAKER   = 4'h1;
  localparam logic [3:0] TAG_MODEL   = 4'h2;
  localparam logic [3:0] TAG_UNIT    = 4'h3;
  localparam logic [3:0] TAG_UNITNUM = 4'h4;
  localparam logic [3:0] TAG_VERSION = 4'h5;
  localparam logic [3:0] TAG_INV     = 4'h6;
  localparam logic [3:0] TAG_PAT     = 4'h7;
  localparam logic [3:0] TAG_PRBS    = 4'h8;
  localparam logic [3:0] TAG_SRE     = 4'h9;
  localparam logic [3:0] TAG_ESE     = 4'ha;
  localparam logic [3:0] TAG_TSE     = 4'hb;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_TEST = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_SEQ  = 4'b1000
  } brsp_state_e;
endpackage

// ### design/brsp_pattern.sv
// Purpose: Pattern source, inversion and pin synchronisers
// Assumes: rx_bit and ref_bit are asynchronous pins
// Notes:   Upper LFSR bits above the exponent are don't-care
module brsp_pattern #(
  parameter bit IS_ANALYZER = 1'b1
) (
  // Clock and reset
  input  logic        core_clk,
  input  logic        rst,
  // Configuration
  input  logic [1:0]  mode,
  input  logic [4:0]  prbs_n,
  input  logic        invert,
  input  logic        reseed,
  input  logic [15:0] word_pattern,
  // Pins
  input  logic        rx_bit,
  input  logic        ref_bit,
  output logic        tx_bit,
  output logic        rx_data,
  output logic        exp_bit,
  // Health
  output logic        prbs_alive
);
  logic [22:0] lfsr_q;
  logic [15:0] word_q;
  logic [4:0]  tap_hi;
  logic [4:0]  tap_lo;
  logic [22:0] mask;
  logic        rx_s1_q, rx_s2_q, ref_s1_q, ref_s2_q;
  logic        pat_bit;

  always_comb begin
    case (prbs_n)
      brsp_pkg::PRBS_N7: begin
        tap_hi = 5'h06; tap_lo = 5'h05; mask = 23'h00007f;
      end
      brsp_pkg::PRBS_N15: begin
        tap_hi = 5'h0e; tap_lo = 5'h0d; mask = 23'h007fff;
      end
      brsp_pkg::PRBS_N17: begin
        tap_hi = 5'h10; tap_lo = 5'h0d; mask = 23'h01ffff;
      end
      brsp_pkg::PRBS_N20: begin
        tap_hi = 5'h13; tap_lo = 5'h02; mask = 23'h0fffff;
      end
      default: begin
        tap_hi = 5'h16; tap_lo = 5'h11; mask = 23'h7fffff;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst || reseed) begin
      lfsr_q <= 23'h7fffff;
    end else begin
      lfsr_q <= {lfsr_q[21:0], lfsr_q[tap_hi] ^ lfsr_q[tap_lo]};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      word_q <= 16'h0000;
    end else if (reseed) begin
      word_q <= word_pattern;
    end else begin
      word_q <= {word_q[14:0], word_q[15]};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_s1_q  <= 1'b0;
      rx_s2_q  <= 1'b0;
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
    end else begin
      rx_s1_q  <= rx_bit;
      rx_s2_q  <= rx_s1_q;
      ref_s1_q <= ref_bit;
      ref_s2_q <= ref_s1_q;
    end
  end

  // PRBS length only affects the pattern bit while PRBS mode is active
  assign pat_bit = (mode == brsp_pkg::MODE_PRBS) ? lfsr_q[tap_hi]
                                                 : word_q[15];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_bit  <= 1'b0;
      rx_data <= 1'b0;
      exp_bit <= 1'b0;
    end else begin
      tx_bit  <= IS_ANALYZER ? 1'b0 : (pat_bit ^ invert);
      rx_data <= rx_s2_q ^ invert;
      exp_bit <= (mode == brsp_pkg::MODE_RDATA) ? ref_s2_q : pat_bit;
    end
  end

  assign prbs_alive = |(lfsr_q & mask);

  a_invert_path: assert property (
    @(posedge core_clk) disable iff (rst)
    rx_data == ($past(rx_s2_q) ^ $past(invert)))
    else $error("analyzer data inversion wrong");
endmodule // brsp_pattern

// ### design/brsp_ctl.sv
// Purpose: Remote status and pattern command handler
// Assumes: Commands come pre-parsed: a code and a binary argument
// Notes:   One command at a time; replies hold until taken
module brsp_ctl #(
  parameter bit          IS_ANALYZER = 1'b1,
  parameter logic [15:0] MAKER_CODE  = 16'h0a5a, // Arbitrary value
  parameter logic [15:0] MODEL_CODE  = 16'h0b6b, // Arbitrary value
  parameter logic [15:0] FW_VERSION  = 16'h0100  // Arbitrary value
) (
  // Clock and reset
  input  logic        core_clk,
  input  logic        rst,
  // Command port
  input  logic        cmd_valid,
  output logic        cmd_ready,
  input  logic [4:0]  cmd_code,
  input  logic [15:0] cmd_arg,
  // Reply port
  output logic        rsp_valid,
  input  logic        rsp_ready,
  output logic [3:0]  rsp_tag,
  output logic [15:0] rsp_value,
  output logic        rsp_last,
  // Test events and service request
  input  logic [7:0]  test_event,
  output logic        srq,
  // Pattern data path
  input  logic [15:0] word_pattern,
  input  logic        rx_bit,
  input  logic        ref_bit,
  output logic        tx_bit,
  output logic        rx_data,
  output logic        exp_bit
);
  brsp_pkg::brsp_state_e st_q, st_d;
  logic [7:0]  sre_q, ese_q, tse_q, esr_q, tstat_q;
  logic        invert_q, opc_pend_q, wait_reply_q, seq_lrn_q;
  logic [1:0]  mode_q;
  logic [4:0]  prbs_n_q;
  logic [7:0]  settle_q, test_cnt_q;
  logic [2:0]  seq_idx_q, seq_last;
  logic        take, arg_ok8, prbs_ok, mode_ok, cfg_change;
  logic        cmd_err, load_rsp, rsp_last_d, opc_set;
  logic        prbs_alive, esb, tss, mss;
  logic [3:0]  rsp_tag_d, seq_tag;
  logic [15:0] rsp_val_d, seq_val;
  logic [7:0]  stb_base, stb;

  assign cmd_ready = (st_q == brsp_pkg::ST_IDLE) && !rsp_valid;
  assign take      = cmd_valid && cmd_ready;
  assign arg_ok8   = (cmd_arg[15:8] == 8'h00);
  assign prbs_ok   = (cmd_arg[15:5] == 11'h000) &&
                     (cmd_arg[4:0] == brsp_pkg::PRBS_N7  ||
                      cmd_arg[4:0] == brsp_pkg::PRBS_N15 ||
                      cmd_arg[4:0] == brsp_pkg::PRBS_N17 ||
                      cmd_arg[4:0] == brsp_pkg::PRBS_N20 ||
                      cmd_arg[4:0] == brsp_pkg::PRBS_N23);
  assign mode_ok   = (cmd_arg == {14'h0000, brsp_pkg::MODE_PRBS}) ||
                     (cmd_arg == {14'h0000, brsp_pkg::MODE_WORD})  ||
                     (IS_ANALYZER &&
                      cmd_arg == {14'h0000, brsp_pkg::MODE_RDATA});
  assign cfg_change = take &&
    ((cmd_code == brsp_pkg::CMD_PAT && mode_ok) ||
     (cmd_code == brsp_pkg::CMD_PRBS && prbs_ok));
  // A clear in the same cycle idles the pending completion instead
  assign opc_set = opc_pend_q && (settle_q == 8'h00) &&
                   !(take && cmd_code == brsp_pkg::CMD_CLS);

  // Status summaries
  assign esb      = |(esr_q & ese_q);
  assign tss      = IS_ANALYZER && |(tstat_q & tse_q);
  assign stb_base = (8'(esb) << brsp_pkg::STB_ESB_BIT) |
                    (8'(tss) << brsp_pkg::STB_TSS_BIT);
  assign mss      = |(stb_base & sre_q & brsp_pkg::MSS_EXCL_MASK);
  assign stb      = stb_base | (8'(mss) << brsp_pkg::STB_MSS_BIT);

  // Enable registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sre_q <= brsp_pkg::RST_ENABLE;
    end else if (take && cmd_code == brsp_pkg::CMD_SRE && arg_ok8) begin
      sre_q <= cmd_arg[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ese_q <= brsp_pkg::RST_ENABLE;
    end else if (take && cmd_code == brsp_pkg::CMD_ESE && arg_ok8) begin
      ese_q <= cmd_arg[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tse_q <= brsp_pkg::RST_ENABLE;
    end else if (IS_ANALYZER && take && cmd_code == brsp_pkg::CMD_TSE &&
                 arg_ok8) begin
      tse_q <= cmd_arg[7:0];
    end
  end

  // Event registers: a set beats a clear in the same cycle, except a completion, which a CLS command suppresses
  always_ff @(posedge core_clk) begin
    if (rst) begin
      esr_q <= 8'h00;
    end else begin
      esr_q <= ((take && (cmd_code == brsp_pkg::CMD_CLS ||
                          cmd_code == brsp_pkg::CMD_ESR_Q)) ? 8'h00 : esr_q)
             | (8'(opc_set) << brsp_pkg::ESR_OPC_BIT)
             | (8'(cmd_err) << brsp_pkg::ESR_CME_BIT);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || !IS_ANALYZER) begin
      tstat_q <= 8'h00;
    end else begin
      tstat_q <= ((take && cmd_code == brsp_pkg::CMD_TSTAT_Q) ? 8'h00
                                                            : tstat_q)
               | test_event;
    end
  end

  // Pattern configuration
  always_ff @(posedge core_clk) begin
    if (rst) begin
      invert_q <= brsp_pkg::RST_INVERT;
    end else if (take && cmd_code == brsp_pkg::CMD_INV) begin
      invert_q <= (cmd_arg != 16'h0000);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_q <= brsp_pkg::RST_MODE;
    end else if (take && cmd_code == brsp_pkg::CMD_PAT && mode_ok) begin
      mode_q <= cmd_arg[1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prbs_n_q <= brsp_pkg::RST_PRBS_N;
    end else if (take && cmd_code == brsp_pkg::CMD_PRBS && prbs_ok) begin
      prbs_n_q <= cmd_arg[4:0];
    end
  end

  // Pattern reseed counts as pending work until it settles
  always_ff @(posedge core_clk) begin
    if (rst) begin
      settle_q <= 8'h00;
    end else if (cfg_change) begin
      settle_q <= brsp_pkg::SETTLE_CNT;
    end else if (settle_q != 8'h00) begin
      settle_q <= settle_q - 8'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      opc_pend_q <= 1'b0;
    end else if (take && cmd_code == brsp_pkg::CMD_CLS) begin
      opc_pend_q <= 1'b0;
    end else if (take && cmd_code == brsp_pkg::CMD_OPC) begin
      opc_pend_q <= 1'b1;
    end else if (opc_set) begin
      opc_pend_q <= 1'b0;
    end
  end

  // Sequencer bookkeeping
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wait_reply_q <= 1'b0;
      seq_lrn_q    <= 1'b0;
    end else if (take) begin
      wait_reply_q <= (cmd_code == brsp_pkg::CMD_OPC_Q);
      seq_lrn_q    <= (cmd_code == brsp_pkg::CMD_LRN_Q);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || take) begin
      seq_idx_q <= 3'h0;
    end else if (st_q == brsp_pkg::ST_SEQ && load_rsp) begin
      seq_idx_q <= seq_idx_q + 3'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      test_cnt_q <= 8'h00;
    end else if (take && cmd_code == brsp_pkg::CMD_TST_Q) begin
      test_cnt_q <= brsp_pkg::SELFTEST_CNT;
    end else if (test_cnt_q != 8'h00) begin
      test_cnt_q <= test_cnt_q - 8'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= brsp_pkg::ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // Multi-beat replies for identify and learn
  assign seq_last = (seq_lrn_q && IS_ANALYZER) ? 3'h5 : 3'h4;
  always_comb begin
    seq_tag = brsp_pkg::TAG_NUM;
    seq_val = 16'h0000;
    case ({seq_lrn_q, seq_idx_q})
      4'h0: begin seq_tag = brsp_pkg::TAG_MAKER;   seq_val = MAKER_CODE; end
      4'h1: begin seq_tag = brsp_pkg::TAG_MODEL;   seq_val = MODEL_CODE; end
      4'h2: begin
        seq_tag = brsp_pkg::TAG_UNIT;
        seq_val = {15'h0000, IS_ANALYZER};
      end
      4'h3: begin seq_tag = brsp_pkg::TAG_UNITNUM; seq_val = 16'h0000; end
      4'h4: begin seq_tag = brsp_pkg::TAG_VERSION; seq_val = FW_VERSION; end
      4'h8: begin
        seq_tag = brsp_pkg::TAG_INV;
        seq_val = {15'h0000, invert_q};
      end
      4'h9: begin seq_tag = brsp_pkg::TAG_PAT; seq_val = {14'h0, mode_q}; end
      4'ha: begin
        seq_tag = brsp_pkg::TAG_PRBS;
        seq_val = {11'h000, prbs_n_q};
      end
      4'hb: begin seq_tag = brsp_pkg::TAG_SRE; seq_val = {8'h00, sre_q}; end
      4'hc: begin seq_tag = brsp_pkg::TAG_ESE; seq_val = {8'h00, ese_q}; end
      4'hd: begin seq_tag = brsp_pkg::TAG_TSE; seq_val = {8'h00, tse_q}; end
      default: begin
        seq_tag = brsp_pkg::TAG_NUM;
        seq_val = 16'h0000;
      end
    endcase
  end

  // Decode, reply selection and next state
  always_comb begin
    st_d       = st_q;
    load_rsp   = 1'b0;
    cmd_err    = 1'b0;
    rsp_tag_d  = brsp_pkg::TAG_NUM;
    rsp_val_d  = 16'h0000;
    rsp_last_d = 1'b1;
    case (st_q)
      brsp_pkg::ST_IDLE: begin
        if (take) begin
          case (cmd_code)
            brsp_pkg::CMD_CLS, brsp_pkg::CMD_OPC, brsp_pkg::CMD_INV: ;
            brsp_pkg::CMD_ESE, brsp_pkg::CMD_SRE: cmd_err = !arg_ok8;
            brsp_pkg::CMD_TSE: cmd_err = !IS_ANALYZER || !arg_ok8;
            brsp_pkg::CMD_PAT: cmd_err = !mode_ok;
            brsp_pkg::CMD_PRBS: cmd_err = !prbs_ok;
            brsp_pkg::CMD_ESE_Q: begin
              load_rsp  = 1'b1;
              rsp_val_d = {8'h00, ese_q};
            end
            brsp_pkg::CMD_ESR_Q: begin
              load_rsp  = 1'b1;
              rsp_val_d = {8'h00, esr_q};
            end
            brsp_pkg::CMD_SRE_Q: begin
              load_rsp  = 1'b1;
              rsp_val_d = {8'h00, sre_q & brsp_pkg::MSS_EXCL_MASK};
            end
            brsp_pkg::CMD_STB_Q: begin
              load_rsp  = 1'b1;
              rsp_val_d = {8'h00, stb};
            end
            brsp_pkg::CMD_TSE_Q: begin
              load_rsp  = IS_ANALYZER;
              cmd_err   = !IS_ANALYZER;
              rsp_val_d = {8'h00, tse_q};
            end
            brsp_pkg::CMD_TSTAT_Q: begin
              load_rsp  = IS_ANALYZER;
              cmd_err   = !IS_ANALYZER;
              rsp_val_d = {8'h00, tstat_q};
            end
            brsp_pkg::CMD_INV_Q: begin
              load_rsp  = 1'b1;
              rsp_val_d = {15'h0000, invert_q};
            end
            brsp_pkg::CMD_PAT_Q: begin
              load_rsp  = 1'b1;
              rsp_val_d = {14'h0000, mode_q};
            end
            brsp_pkg::CMD_PRBS_Q: begin
              load_rsp  = 1'b1;
              rsp_val_d = {11'h000, prbs_n_q};
            end
            brsp_pkg::CMD_IDN_Q, brsp_pkg::CMD_LRN_Q: st_d = brsp_pkg::ST_SEQ;
            brsp_pkg::CMD_TST_Q: st_d = brsp_pkg::ST_TEST;
            brsp_pkg::CMD_OPC_Q, brsp_pkg::CMD_WAI: st_d = brsp_pkg::ST_WAIT;
            default: cmd_err = 1'b1;
          endcase
        end
      end
      brsp_pkg::ST_TEST: begin
        if (test_cnt_q == 8'h00) begin
          load_rsp  = 1'b1;
          rsp_val_d = prbs_alive ? 16'h0000 : 16'h0001;
          st_d      = brsp_pkg::ST_IDLE;
        end
      end
      brsp_pkg::ST_WAIT: begin
        if (settle_q == 8'h00) begin
          load_rsp  = wait_reply_q;
          rsp_val_d = brsp_pkg::OPC_ASCII_ONE;
          st_d      = brsp_pkg::ST_IDLE;
        end
      end
      brsp_pkg::ST_SEQ: begin
        if (!rsp_valid || rsp_ready) begin
          load_rsp   = 1'b1;
          rsp_tag_d  = seq_tag;
          rsp_val_d  = seq_val;
          rsp_last_d = (seq_idx_q == seq_last);
          if (seq_idx_q == seq_last) begin
            st_d = brsp_pkg::ST_IDLE;
          end
        end
      end
      default: st_d = brsp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_tag   <= brsp_pkg::TAG_NUM;
      rsp_value <= 16'h0000;
      rsp_last  <= 1'b0;
    end else if (load_rsp) begin
      rsp_valid <= 1'b1;
      rsp_tag   <= rsp_tag_d;
      rsp_value <= rsp_val_d;
      rsp_last  <= rsp_last_d;
    end else if (rsp_ready) begin
      rsp_valid <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      srq <= 1'b0;
    end else begin
      srq <= mss;
    end
  end

  brsp_pattern #(
    .IS_ANALYZER (IS_ANALYZER)
  ) u_pattern (
    .core_clk     (core_clk),
    .rst          (rst),
    .mode         (mode_q),
    .prbs_n       (prbs_n_q),
    .invert       (invert_q),
    .reseed       (cfg_change),
    .word_pattern (word_pattern),
    .rx_bit       (rx_bit),
    .ref_bit      (ref_bit),
    .tx_bit       (tx_bit),
    .rx_data      (rx_data),
    .exp_bit      (exp_bit),
    .prbs_alive   (prbs_alive)
  );

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_opc_take;
    take && cmd_code == brsp_pkg::CMD_OPC && settle_q == 8'h00;
  endsequence
  sequence s_no_clear;
    !(take && cmd_code == brsp_pkg::CMD_CLS);
  endsequence

  a_sre_load: assert property (
    take && cmd_code == brsp_pkg::CMD_SRE && arg_ok8
    |=> sre_q == $past(cmd_arg[7:0]))
    else $error("service enable not loaded");
  a_arg_reject: assert property (
    take && cmd_code == brsp_pkg::CMD_ESE && !arg_ok8
    |=> $stable(ese_q) && esr_q[brsp_pkg::ESR_CME_BIT])
    else $error("bad enable argument accepted");
  a_sre_query: assert property (
    take && cmd_code == brsp_pkg::CMD_SRE_Q
    |=> rsp_valid && !rsp_value[6] &&
        rsp_value[7:0] == ($past(sre_q) & 8'hbf))
    else $error("service enable query wrong");
  a_summary_srq: assert property (
    (stb_base & sre_q & 8'hbf) != 8'h00 |=> srq)
    else $error("service request missing");
  a_opc_event: assert property (
    s_opc_take ##1 s_no_clear |-> ##1 esr_q[brsp_pkg::ESR_OPC_BIT])
    else $error("completion bit not set");
  a_opc_reply: assert property (
    take && cmd_code == brsp_pkg::CMD_OPC_Q
    |-> ##[1:40] rsp_valid && rsp_value == 16'h0031 &&
        $past(settle_q) == 8'h00)
    else $error("completion query reply wrong");
  a_wait_stall: assert property (
    st_q == brsp_pkg::ST_WAIT && settle_q != 8'h00
    |-> !cmd_ready ##1 st_q == brsp_pkg::ST_WAIT)
    else $error("command taken while work pending");
  a_test_reply: assert property (
    take && cmd_code == brsp_pkg::CMD_TST_Q
    |-> ##[2:120] rsp_valid && (rsp_value == 16'h0000) == $past(prbs_alive))
    else $error("self test reply wrong");
  a_prbs_store: assert property (
    take && cmd_code == brsp_pkg::CMD_PRBS && prbs_ok
    |=> prbs_n_q == $past(cmd_arg[4:0]))
    else $error("prbs exponent not stored");
  a_cls_clear: assert property (
    take && cmd_code == brsp_pkg::CMD_CLS |=> esr_q == 8'h00 && !opc_pend_q)
    else $error("clear status incomplete");
  a_mode_guard: assert property (
    take && cmd_code == brsp_pkg::CMD_PAT && !mode_ok |=> $stable(mode_q))
    else $error("illegal pattern mode accepted");
endmodule // brsp_ctl

// ### tb/brsp_host.sv
// Purpose: Remote controller side, consumes reply beats
// Assumes: One beat is taken after DLY waiting cycles
// Notes:   A slow taker checks that replies hold
module brsp_host #(
  parameter int DLY = 3
) (
  // Clock
  input  logic core_clk,
  // Reply handshake
  input  logic rsp_valid,
  output logic rsp_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  always @(posedge core_clk) begin
    cnt <= (rsp_valid && !rsp_ready) ? cnt + 1 : 0;
  end
  assign rsp_ready = rsp_valid && cnt >= DLY;
endmodule // brsp_host

// ### tb/tb_brsp_ctl.sv
// Purpose: Self-checking bench for the command handler
// Assumes: Analyzer build, one command at a time
// Notes:   Values are checked when the reply is taken
module tb_brsp_ctl;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, rx_bit = 1'b1;
  logic        ref_bit = 1'b0;
  logic [4:0]  cmd_code = 5'h00;
  logic [15:0] cmd_arg = 16'h0000;
  logic [7:0]  test_event = 8'h00;
  logic        cmd_ready, rsp_valid, rsp_ready, rsp_last, srq;
  logic        tx_bit, rx_data, exp_bit;
  logic [3:0]  rsp_tag;
  logic [15:0] rsp_value;
  int          err_total = 0, total_checks = 0;
  always #50 core_clk = ~core_clk;
  localparam logic [15:0] MAKER = 16'h0c3c; // Arbitrary value
  localparam logic [15:0] MODEL = 16'h0d4d; // Arbitrary value
  localparam logic [15:0] FWVER = 16'h0220; // Arbitrary value
  brsp_ctl #(.IS_ANALYZER(1'b1), .MAKER_CODE(MAKER), .MODEL_CODE(MODEL),
    .FW_VERSION(FWVER)) dut (.core_clk, .rst, .cmd_valid, .cmd_ready,
    .cmd_code, .cmd_arg, .rsp_valid, .rsp_ready, .rsp_tag, .rsp_value,
    .rsp_last, .test_event, .srq, .word_pattern(16'h0000), .rx_bit,
    .ref_bit, .tx_bit, .rx_data, .exp_bit);
  brsp_host host (.core_clk, .rsp_valid, .rsp_ready);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [4:0] c, input logic [15:0] a);
    int n = 0;
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_arg <= a;
    do @(negedge core_clk); while (cmd_ready !== 1'b1 && ++n < 300);
    if (n >= 300) begin
      err_total++;
      $display("Error %0t: command not taken", $time);
    end
    @(posedge core_clk);
    cmd_valid <= 1'b0;
  endtask
  // One reply beat, judged at the cycle the host takes it
  task automatic beat(input logic [3:0] t, input logic [15:0] v,
                      input logic l);
    int n = 0;
    do @(negedge core_clk); while (!(rsp_valid && rsp_ready) && ++n < 300);
    if (n >= 300) begin
      err_total++;
      $display("Error %0t: no reply beat", $time);
    end
    chk(rsp_value, v);
    chk({11'h000, rsp_last, rsp_tag}, {11'h000, l, t});
  endtask
  task automatic ask(input logic [4:0] c, input logic [15:0] exp);
    send(c, 16'h0000);
    beat(brsp_pkg::TAG_NUM, exp, 1'b1);
  endtask
  task automatic t_enables;
    send(brsp_pkg::CMD_SRE, 16'h0030);
    ask(brsp_pkg::CMD_SRE_Q, 16'h0030);
    send(brsp_pkg::CMD_SRE, 16'h01ff);
    ask(brsp_pkg::CMD_SRE_Q, 16'h0030);
    send(brsp_pkg::CMD_SRE, 16'h00ff);
    ask(brsp_pkg::CMD_SRE_Q, 16'h00bf);
    send(brsp_pkg::CMD_ESE, 16'h0012);
    ask(brsp_pkg::CMD_ESE_Q, 16'h0012);
    send(brsp_pkg::CMD_ESE, 16'h0100);
    ask(brsp_pkg::CMD_ESE_Q, 16'h0012);
  endtask
  task automatic t_pattern;
    send(brsp_pkg::CMD_PRBS, 16'h000f);
    send(brsp_pkg::CMD_WAI, 16'h0000);
    ask(brsp_pkg::CMD_PRBS_Q, 16'h000f);
    send(brsp_pkg::CMD_PRBS, 16'h0009);
    ask(brsp_pkg::CMD_PRBS_Q, 16'h000f);
    send(brsp_pkg::CMD_PAT, 16'h0002);
    ask(brsp_pkg::CMD_PAT_Q, 16'h0002);
    @(posedge core_clk);
    ref_bit <= 1'b1;
    repeat (4) @(negedge core_clk);
    chk({15'h0000, exp_bit}, 16'h0001);
    send(brsp_pkg::CMD_PAT, 16'h0001);
    ask(brsp_pkg::CMD_PAT_Q, 16'h0001);
    // Word of zeros must hide the reference pin
    chk({15'h0000, exp_bit}, 16'h0000);
    send(brsp_pkg::CMD_PAT, 16'h0003);
    ask(brsp_pkg::CMD_PAT_Q, 16'h0001);
    send(brsp_pkg::CMD_PAT, 16'h0000);
    ask(brsp_pkg::CMD_OPC_Q, 16'h0031);
    ask(brsp_pkg::CMD_TST_Q, 16'h0000);
  endtask
  task automatic t_invert;
    chk({15'h0000, rx_data}, 16'h0001);
    chk({15'h0000, tx_bit}, 16'h0000);
    send(brsp_pkg::CMD_INV, 16'h0001);
    ask(brsp_pkg::CMD_INV_Q, 16'h0001);
    repeat (4) @(negedge core_clk);
    chk({15'h0000, rx_data}, 16'h0000);
  endtask
  task automatic t_status;
    send(brsp_pkg::CMD_TSE, 16'h00ff);
    @(posedge core_clk);
    test_event <= 8'h04;
    @(posedge core_clk);
    test_event <= 8'h00;
    // Test summary bit 3 enabled, so summary bit 6 too
    ask(brsp_pkg::CMD_STB_Q, 16'h0048);
    chk({15'h0000, srq}, 16'h0001);
    ask(brsp_pkg::CMD_TSTAT_Q, 16'h0004);
    ask(brsp_pkg::CMD_TSE_Q, 16'h00ff);
    send(brsp_pkg::CMD_LRN_Q, 16'h0000);
    beat(brsp_pkg::TAG_INV, 16'h0001, 1'b0);
    beat(brsp_pkg::TAG_PAT, 16'h0000, 1'b0);
    beat(brsp_pkg::TAG_PRBS, 16'h000f, 1'b0);
    beat(brsp_pkg::TAG_SRE, 16'h00ff, 1'b0);
    beat(brsp_pkg::TAG_ESE, 16'h0012, 1'b0);
    beat(brsp_pkg::TAG_TSE, 16'h00ff, 1'b1);
  endtask
  task automatic t_events;
    ask(brsp_pkg::CMD_ESR_Q, 16'h0020);
    send(brsp_pkg::CMD_ESE, 16'h0001);
    send(brsp_pkg::CMD_OPC, 16'h0000);
    repeat (3) @(negedge core_clk);
    chk({15'h0000, srq}, 16'h0001);
    ask(brsp_pkg::CMD_STB_Q, 16'h0060);
    send(brsp_pkg::CMD_SRE, 16'h0100);
    send(brsp_pkg::CMD_CLS, 16'h0000);
    ask(brsp_pkg::CMD_STB_Q, 16'h0000);
    ask(brsp_pkg::CMD_ESR_Q, 16'h0000);
  endtask
  task automatic t_ident;
    send(brsp_pkg::CMD_IDN_Q, 16'h0000);
    beat(brsp_pkg::TAG_MAKER, MAKER, 1'b0);
    beat(brsp_pkg::TAG_MODEL, MODEL, 1'b0);
    beat(brsp_pkg::TAG_UNIT, 16'h0001, 1'b0);
    beat(brsp_pkg::TAG_UNITNUM, 16'h0000, 1'b0);
    beat(brsp_pkg::TAG_VERSION, FWVER, 1'b1);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #(4000 * 100);
    err_total++;
    final_report;
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    t_enables;
    t_pattern;
    t_invert;
    t_status;
    t_events;
    t_ident;
    final_report;
  end
endmodule // tb_brsp_ctl
